// ===== src/rgp_pkg.sv
// package: register map, reset values, timing constants and carriers
package rgp_pkg;
    localparam logic [3:0] ADDR_PWR_CFG = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_CMD = 4'h2;
    localparam logic [3:0] ADDR_REF_DIV = 4'h3;
    localparam logic [3:0] ADDR_OFF_HI = 4'h4;
    localparam logic [3:0] ADDR_OFF_LO = 4'h5;
    localparam logic [3:0] ADDR_WAKE = 4'h6;
    localparam logic [3:0] ADDR_RF_HI = 4'h7;
    localparam logic [3:0] ADDR_RF_LO = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    localparam logic [3:0] ADDR_GAIN_HOLD = 4'hA;
    localparam logic [7:0] RST_GAIN_HOLD = 8'h0D;
    localparam logic [7:0] RST_REF_DIV = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // cfg register fields
    localparam int CFG_DRX_BIT = 2;
    localparam int CFG_AGC_EN_BIT = 3;
    localparam int CFG_BASE_LO_BIT = 0;
    localparam int CFG_BASE_HI_BIT = 1;
    // command codes written to the command register
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h01;
    localparam logic [7:0] CMD_SLEEP = 8'h02;
    localparam logic [7:0] CMD_WAKE = 8'h03;
    // time bases
    localparam int CLK_MHZ = 125;
    localparam int BASE_US = 120;
    localparam int BASE_CYC = BASE_US * CLK_MHZ;
    localparam logic [1:0] WAKE_BIT = 2'd0;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rgp_req_t;
endpackage

// ===== src/rgp_interval.sv
// interval counter: counts ticks up to a target, pulses done
`timescale 1ns/1ps
module rgp_interval
    import rgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic start,
    input wire logic tick,
    input wire logic [15:0] target,
    output logic done
);
    logic run;
    logic [15:0] cnt;
    logic next_run;
    logic [15:0] next_cnt;
    logic next_done;

    always_comb begin
        next_run = run;
        next_cnt = cnt;
        next_done = 1'b0;
        if (clr) begin
            next_run = 1'b0;
            next_cnt = '0;
        end else if (start) begin
            next_run = 1'b1;
            next_cnt = '0;
        end else if (run && (cnt >= target)) begin
            next_run = 1'b0;
            next_done = 1'b1;
        end else if (run && tick) begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 1'b0;
            cnt <= '0;
            done <= 1'b0;
        end else begin
            run <= next_run;
            cnt <= next_cnt;
            done <= next_done;
        end
    end
endmodule

// ===== src/rgp_core.sv
// receiver control: registers, gain hold, power sequencing, commands
`timescale 1ns/1ps
module rgp_core
    import rgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire rgp_req_t req,
    output logic [7:0] rdata,
    input wire logic above_upper,
    input wire logic below_lower,
    output logic gain_reduce,
    output logic [7:0] power_en,
    output logic sleeping,
    output logic ref_tick
);
    logic [7:0] regs [0:10];
    logic [7:0] next_regs [0:10];
    logic sleep_q, next_sleep;
    logic soft_rst;
    logic wr_cmd;
    assign wr_cmd = req.wr && (req.addr == ADDR_CMD);
    assign soft_rst = wr_cmd && (req.wdata == CMD_RESET);

    // register file
    always_comb begin
        for (int i = 0; i <= 10; i++) begin
            next_regs[i] = regs[i];
        end
        next_sleep = sleep_q;
        if (soft_rst) begin
            for (int i = 0; i <= 10; i++) begin
                next_regs[i] = RST_ZERO;
            end
            next_regs[ADDR_GAIN_HOLD] = RST_GAIN_HOLD;
            next_sleep = 1'b0;
        end else if (wr_cmd) begin
            if (req.wdata == CMD_SLEEP) begin
                next_sleep = 1'b1;
            end else if (req.wdata == CMD_WAKE) begin
                next_sleep = 1'b0;
            end
        end else if (req.wr && req.addr <= ADDR_GAIN_HOLD && req.addr != ADDR_STATUS) begin
            next_regs[req.addr] = req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i <= 10; i++) begin
                regs[i] <= RST_ZERO;
            end
            regs[ADDR_GAIN_HOLD] <= RST_GAIN_HOLD;
            sleep_q <= 1'b0;
        end else begin
            for (int i = 0; i <= 10; i++) begin
                regs[i] <= next_regs[i];
            end
            sleep_q <= next_sleep;
        end
    end
    assign sleeping = sleep_q;

    // reference divider
    logic [7:0] div_cnt, next_div_cnt;
    logic next_ref_tick;
    always_comb begin
        next_div_cnt = div_cnt + 8'h01;
        next_ref_tick = 1'b0;
        if (div_cnt + 8'h01 >= regs[ADDR_REF_DIV]) begin
            next_div_cnt = 8'h00;
            next_ref_tick = (regs[ADDR_REF_DIV] != 8'h00);
        end
    end

    // gain hold
    typedef enum logic [1:0] {G_HIGH, G_LOW, G_HOLD} rgp_gain_t;
    rgp_gain_t gst, next_gst;
    logic [31:0] hcnt, next_hcnt;
    logic hold_end;
    assign hold_end = (regs[ADDR_GAIN_HOLD] >= 8'h20) ? 1'b0 :
        (hcnt + 32'h1 >= (32'h1 << regs[ADDR_GAIN_HOLD][4:0]));
    always_comb begin
        next_gst = gst;
        next_hcnt = hcnt;
        unique case (gst)
            G_HIGH: begin
                if (regs[ADDR_CFG][CFG_AGC_EN_BIT] && above_upper) begin
                    next_gst = G_LOW;
                end
            end
            G_LOW: begin
                if (below_lower) begin
                    next_gst = G_HOLD;
                    next_hcnt = '0;
                end
            end
            G_HOLD: begin
                if (!below_lower) begin
                    next_gst = G_LOW;
                    next_hcnt = '0;
                end else if (hold_end) begin
                    next_gst = G_HIGH;
                end else begin
                    next_hcnt = hcnt + 32'h1;
                end
            end
            default: next_gst = G_HIGH;
        endcase
        if (!regs[ADDR_CFG][CFG_AGC_EN_BIT]) begin
            next_gst = G_HIGH;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gst <= G_HIGH;
            hcnt <= '0;
            div_cnt <= 8'h00;
            ref_tick <= 1'b0;
        end else begin
            gst <= next_gst;
            hcnt <= next_hcnt;
            div_cnt <= next_div_cnt;
            ref_tick <= next_ref_tick;
        end
    end
    assign gain_reduce = (gst != G_HIGH);

    // 120 us base tick and off-interval prescale
    logic [13:0] base_cnt, next_base_cnt;
    logic base_tick;
    logic off_tick;
    logic [1:0] sel;
    logic [5:0] pre4, next_pre4;
    logic off_start, wake_start, rf_start, dclr;
    logic base_restart;
    assign sel = {regs[ADDR_CFG][CFG_BASE_HI_BIT], regs[ADDR_CFG][CFG_BASE_LO_BIT]};
    assign base_tick = (base_cnt == 14'(BASE_CYC - 1));
    assign base_restart = dclr || off_start || wake_start || rf_start;
    assign off_tick = base_tick && (next_pre4 == 6'h00);
    always_comb begin
        next_base_cnt = base_tick ? 14'h0000 : base_cnt + 14'h0001;
        next_pre4 = pre4;
        if (base_tick) begin
            unique case (sel)
                2'h0: next_pre4 = 6'h00;
                2'h1: next_pre4 = (pre4 >= 6'h03) ? 6'h00 : pre4 + 6'h01;
                2'h2: next_pre4 = (pre4 >= 6'h0F) ? 6'h00 : pre4 + 6'h01;
                2'h3: next_pre4 = (pre4 >= 6'h3F) ? 6'h00 : pre4 + 6'h01;
            endcase
        end
        if (base_restart) begin
            next_base_cnt = 14'h0000;
            next_pre4 = 6'h00;
        end
    end

    // discontinuous sequencing
    typedef enum logic [1:0] {D_OFF, D_WAKE, D_SETTLE, D_ON} rgp_drx_t;
    rgp_drx_t dst, next_dst;
    logic discontinuous_receive;
    logic off_done, wake_done, rf_done;
    assign discontinuous_receive = regs[ADDR_CFG][CFG_DRX_BIT];
    assign dclr = !discontinuous_receive || sleep_q;
    always_comb begin
        next_dst = dst;
        off_start = 1'b0;
        wake_start = 1'b0;
        rf_start = 1'b0;
        unique case (dst)
            D_OFF: if (off_done) begin
                next_dst = D_WAKE;
                wake_start = 1'b1;
            end
            D_WAKE: if (wake_done) begin
                next_dst = D_SETTLE;
                rf_start = 1'b1;
            end
            D_SETTLE: if (rf_done) begin
                next_dst = D_ON;
            end
            D_ON: begin
                next_dst = D_OFF;
                off_start = 1'b1;
            end
        endcase
        if (dclr) begin
            next_dst = D_ON;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dst <= D_ON;
            base_cnt <= '0;
            pre4 <= '0;
        end else begin
            dst <= next_dst;
            base_cnt <= next_base_cnt;
            pre4 <= next_pre4;
        end
    end

    rgp_interval u_off (.clk(clk), .rst_n(rst_n), .clr(dclr), .start(off_start),
        .tick(off_tick), .target({regs[ADDR_OFF_HI], regs[ADDR_OFF_LO]}), .done(off_done));
    rgp_interval u_wake (.clk(clk), .rst_n(rst_n), .clr(dclr), .start(wake_start),
        .tick(base_tick), .target({8'h00, regs[ADDR_WAKE]}), .done(wake_done));
    rgp_interval u_rf (.clk(clk), .rst_n(rst_n), .clr(dclr), .start(rf_start),
        .tick(base_tick), .target({regs[ADDR_RF_HI], regs[ADDR_RF_LO]}), .done(rf_done));

    // power enables and read data
    logic [7:0] next_power_en, next_rdata;
    always_comb begin
        if (sleep_q) begin
            next_power_en = 8'h00;
        end else if (!discontinuous_receive) begin
            next_power_en = regs[ADDR_PWR_CFG];
        end else begin
            next_power_en = (dst == D_OFF || dst == D_WAKE) ? 8'h00 : regs[ADDR_PWR_CFG];
        end
        next_rdata = rdata;
        if (req.rd) begin
            if (req.addr == ADDR_STATUS) begin
                next_rdata = {3'b000, sleep_q, gain_reduce, discontinuous_receive, 2'(dst)};
            end else if (req.addr <= ADDR_GAIN_HOLD) begin
                next_rdata = regs[req.addr];
            end else begin
                next_rdata = 8'h00;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_en <= 8'h00;
            rdata <= 8'h00;
        end else begin
            power_en <= next_power_en;
            rdata <= next_rdata;
        end
    end

    property p_hold_reset;
        @(posedge clk) disable iff (!rst_n)
            soft_rst |=> regs[ADDR_GAIN_HOLD] == RST_GAIN_HOLD;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("hold value not restored");
    property p_agc_on;
        @(posedge clk) disable iff (!rst_n)
            (gst == G_HIGH && regs[ADDR_CFG][CFG_AGC_EN_BIT] && above_upper && !soft_rst)
            |=> gain_reduce;
    endproperty
    a_agc_on: assert property (p_agc_on) else $error("gain not reduced");
    property p_cont;
        @(posedge clk) disable iff (!rst_n)
            (!discontinuous_receive && !sleep_q) |=> power_en == $past(regs[ADDR_PWR_CFG]);
    endproperty
    a_cont: assert property (p_cont) else $error("enables not following register");
    property p_sleep;
        @(posedge clk) disable iff (!rst_n)
            (wr_cmd && req.wdata == CMD_SLEEP) |=> sleeping;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_nop;
        @(posedge clk) disable iff (!rst_n)
            (wr_cmd && req.wdata == CMD_NOP) |=> $stable(regs[ADDR_GAIN_HOLD]) && $stable(sleep_q);
    endproperty
    a_nop: assert property (p_nop) else $error("no-operation changed state");
    sequence s_hold_rise;
        gst == G_HOLD && !below_lower && regs[ADDR_CFG][CFG_AGC_EN_BIT];
    endsequence
    property p_hold_restart;
        @(posedge clk) disable iff (!rst_n) s_hold_rise |=> (gst == G_LOW && hcnt == 32'h0);
    endproperty
    a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted");
    property p_wake_off;
        @(posedge clk) disable iff (!rst_n)
            (discontinuous_receive && !sleep_q && (dst == D_OFF || dst == D_WAKE)) |=> power_en == 8'h00;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("powered while off");
endmodule

// ===== verification/rgp_host.sv
// host model: register writes and reads through the request port
`timescale 1ns/1ps
module rgp_host
    import rgp_pkg::*;
#(
    parameter logic [7:0] QUICK_START = 8'h1F
)
(
    input wire logic clk,
    output rgp_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req <= '0;
        @(negedge clk);
        d = rdata;
    endtask
    // power register with the quick start enables
    task automatic quick_start();
        wr(ADDR_PWR_CFG, QUICK_START);
    endtask
    // timers are written before discontinuous mode is turned on
    task automatic drx_setup(input logic [15:0] off, input logic [7:0] wk, input logic [15:0] rf);
        wr(ADDR_OFF_HI, off[15:8]);
        wr(ADDR_OFF_LO, off[7:0]);
        wr(ADDR_WAKE, wk);
        wr(ADDR_RF_HI, rf[15:8]);
        wr(ADDR_RF_LO, rf[7:0]);
    endtask
endmodule

// ===== verification/rx_gain_hold_and_power_control_test.sv
// testbench: registers, reference tick, gain hold, commands, power modes
`timescale 1ns/1ps
module rx_gain_hold_and_power_control_test
    import rgp_pkg::*;
;
    localparam logic [7:0] QS = 8'h1F;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic above_upper = 1'b0;
    logic below_lower = 1'b0;
    rgp_req_t req;
    logic [7:0] rdata;
    logic [7:0] power_en;
    logic gain_reduce;
    logic sleeping;
    logic ref_tick;
    int errors = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    rgp_core i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .req(req),
        .rdata(rdata),
        .above_upper(above_upper),
        .below_lower(below_lower),
        .gain_reduce(gain_reduce),
        .power_en(power_en),
        .sleeping(sleeping),
        .ref_tick(ref_tick)
    );
    rgp_host #(.QUICK_START(QS)) i_host (
        .clk(clk),
        .req(req),
        .rdata(rdata)
    );
    function automatic int hold_cycles(input logic [7:0] h);
        return 1 << h;
    endfunction
    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string m, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        cmp("read", d, exp);
    endtask
    task automatic flag(input bit pick_sleep, input logic exp, input int n);
        repeat (n) @(negedge clk);
        cmp("flag", {7'h00, pick_sleep ? sleeping : gain_reduce}, {7'h00, exp});
    endtask
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ref_tick !== 1'b1 && n < 600);
    endtask
    task automatic wait_pe(input logic [7:0] e, input int lim, output int n);
        n = 0;
        while (power_en !== e && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        #(60000 * 8);
        errors++;
        end_sim();
    end
    initial begin
        logic [7:0] v;
        int n;
        void'($urandom(32'hCC91F913));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk_rd(ADDR_GAIN_HOLD, RST_GAIN_HOLD);
        for (int a = 3; a < 9; a++) chk_rd(4'(a), RST_ZERO);
        chk_rd(4'hB, 8'h00);
        repeat (4) begin
            v = 8'($urandom);
            i_host.wr(ADDR_GAIN_HOLD, v);
            chk_rd(ADDR_GAIN_HOLD, v);
        end
        i_host.wr(ADDR_GAIN_HOLD, 8'hFF);
        chk_rd(ADDR_GAIN_HOLD, 8'hFF);
        v = 8'($urandom_range(9, 2));
        i_host.wr(ADDR_REF_DIV, v);
        chk_rd(ADDR_REF_DIV, v);
        tick_gap(n);
        tick_gap(n);
        cmp("tick period", 8'(n), v);
        i_host.quick_start();
        repeat (2) @(negedge clk);
        cmp("power", power_en, QS);
        repeat (3) begin
            v = 8'($urandom);
            i_host.wr(ADDR_PWR_CFG, v);
            repeat (2) @(negedge clk);
            cmp("power", power_en, v);
        end
        above_upper = 1'b1;
        flag(1'b0, 1'b0, 3);
        above_upper = 1'b0;
        i_host.wr(ADDR_CFG, 8'h08);
        i_host.wr(ADDR_GAIN_HOLD, 8'h05);
        above_upper = 1'b1;
        flag(1'b0, 1'b1, 3);
        above_upper = 1'b0;
        below_lower = 1'b1;
        flag(1'b0, 1'b1, hold_cycles(8'h05) - 4);
        flag(1'b0, 1'b0, 8);
        above_upper = 1'b1;
        flag(1'b0, 1'b1, 3);
        above_upper = 1'b0;
        flag(1'b0, 1'b1, 20);
        below_lower = 1'b0;
        repeat (2) @(negedge clk);
        below_lower = 1'b1;
        flag(1'b0, 1'b1, hold_cycles(8'h05) - 4);
        flag(1'b0, 1'b0, 8);
        above_upper = 1'b1;
        flag(1'b0, 1'b1, 3);
        above_upper = 1'b0;
        below_lower = 1'b0;
        flag(1'b0, 1'b1, hold_cycles(8'h05) + 8);
        i_host.wr(ADDR_GAIN_HOLD, 8'h21);
        i_host.wr(ADDR_CMD, CMD_NOP);
        chk_rd(ADDR_GAIN_HOLD, 8'h21);
        i_host.wr(ADDR_CMD, CMD_SLEEP);
        flag(1'b1, 1'b1, 2);
        cmp("sleep power", power_en, 8'h00);
        chk_rd(ADDR_STATUS, 8'h1B);
        i_host.wr(ADDR_CMD, CMD_WAKE);
        flag(1'b1, 1'b0, 2);
        i_host.wr(ADDR_CMD, CMD_RESET);
        chk_rd(ADDR_GAIN_HOLD, RST_GAIN_HOLD);
        chk_rd(ADDR_REF_DIV, RST_REF_DIV);
        chk_rd(ADDR_CFG, RST_ZERO);
        i_host.drx_setup(16'h0001, 8'h01, 16'h0001);
        chk_rd(ADDR_OFF_LO, 8'h01);
        chk_rd(ADDR_WAKE, 8'h01);
        chk_rd(ADDR_RF_LO, 8'h01);
        i_host.quick_start();
        i_host.wr(ADDR_CFG, 8'h04);
        wait_pe(8'h00, 16, n);
        cmp("drx off", power_en, 8'h00);
        wait_pe(QS, 3 * BASE_CYC, n);
        cmp("drx on", power_en, QS);
        cmp("off span", {7'h00, n >= 2 * BASE_CYC}, 8'h01);
        cmp("off span", {7'h00, n <= 2 * BASE_CYC + 8}, 8'h01);
        wait_pe(8'h00, 2 * BASE_CYC, n);
        cmp("settle span", {7'h00, n >= BASE_CYC && n <= BASE_CYC + 8}, 8'h01);
        end_sim();
    end
endmodule
